// ===== hw/uart_rx_modes_pkg.sv
//------------------------------------------------------------------------------
// Overview of operation
// - Armed start edge wakes oscillator and receiver clock
// - False start without other wake drops clock
// - Detection async only, own enable, sets flag
// - Detection operative in standby sleep only
// - Start and complete flags share one line
// - Both interrupts off: oscillator and receiver clock, no wake
// - Wake on start, else on complete, per enables
// - Oscillator stays on while reception runs
// - Break is more than eleven low bit times
// - Strict mode: bad sync sets flag, baud kept
// - Count sync from start bit over eight bits
// - Count upper ten integer, lower six fraction
// - Generic mode: no pattern check, range gated
// - Wait-for-break: next fall then rise is break
// - One-wire: transmit looped into receive input
// - Frame type is stop bit or ninth bit
// - Filter drops every data frame, keeps address frames
// - Infrared mode code, no double speed, inverted pins
// - Infrared pulse: 3/16, fixed clocks, or none
// - Long enough high pulse decodes zero, else one
// - Event input source disconnects receive pin
// - Pending request held until flag cleared
//------------------------------------------------------------------------------
package uart_rx_modes_pkg;

  //----------------------------------------------------------------------------
  // Register map
  //----------------------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam logic [7:0]  BAUD_OFFSET     = 8'h08;
  localparam logic [7:0]  TX_PULSE_OFFSET = 8'h0c;
  localparam logic [7:0]  RX_PULSE_OFFSET = 8'h10;
  localparam logic [7:0]  RX_DATA_OFFSET  = 8'h14;
  localparam logic [7:0]  TX_DATA_OFFSET  = 8'h18;

  localparam logic [18:0] CTRL_RESET      = 19'h0_2000;
  localparam logic [15:0] BAUD_RESET      = 16'h0400;
  localparam logic [7:0]  TX_PULSE_RESET  = 8'h08;
  localparam logic [6:0]  RX_PULSE_RESET  = 7'h04;

  //----------------------------------------------------------------------------
  // Timing figures
  //----------------------------------------------------------------------------
  localparam logic [16:0] ACC_STEP        = 17'h0_0040;
  localparam logic [16:0] ACC_STEP_2X     = 17'h0_0080;
  localparam logic [19:0] SYNC_STEP       = 20'h0_0008;
  localparam logic [23:0] BREAK_BITS      = 24'h00_000b;
  localparam logic [2:0]  SYNC_FALLS      = 3'h4;
  localparam logic [2:0]  SYNC_RISES      = 3'h4;
  localparam logic [19:0] BAUD_MIN        = 20'h0_0064;
  localparam logic [19:0] BAUD_MAX        = 20'h0_ffff;

  typedef enum logic [1:0] {RXM_NORMAL = 2'b00, RXM_GENERIC = 2'b01,
                            RXM_STRICT = 2'b10} rx_mode_t;
  typedef enum logic [1:0] {CM_ASYNC = 2'b00, CM_SYNC = 2'b01,
                            CM_INFRARED = 2'b10} comm_mode_t;
  typedef enum logic [1:0] {IRP_3_16 = 2'b00, IRP_FIXED = 2'b01,
                            IRP_NONE = 2'b10} ir_pulse_t;
  typedef enum logic [1:0] {SLP_ACTIVE = 2'b00, SLP_IDLE = 2'b01,
                            SLP_STANDBY = 2'b10, SLP_POWERDOWN = 2'b11} sleep_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
                            RX_STOP = 3'b011, AB_BREAK = 3'b100, AB_SYNC_WAIT = 3'b101,
                            AB_MEASURE = 3'b110, AB_TAIL = 3'b111} rx_state_t;

  typedef struct packed {
    logic       start_int_en;
    logic       done_int_en;
    logic       event_input_select;
    logic [1:0] ir_tx_pulse_mode;
    logic [3:0] char_size;
    logic       double_speed;
    logic [1:0] communication_mode_field;
    logic [1:0] receive_mode_select;
    logic       multiprocessor_filter_mode;
    logic       one_wire_mode;
    logic       start_frame_detect_enable;
    logic       tx_enable;
    logic       rx_enable;
  } ctrl_t;

  typedef struct packed {
    logic rx_busy;
    logic wait_for_break;
    logic break_flag;
    logic inconsistent_sync_flag;
    logic start_detected_flag;
    logic receive_complete_flag;
  } status_t;

endpackage

// ===== hw/uart_rx_special_modes.sv
`timescale 1ns/100ps
module uart_rx_special_modes
  import uart_rx_modes_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        receive_pin,
  input  wire logic        event_rx_in,
  input  wire logic [1:0]  sleep_state,
  input  wire logic        other_wake,
  output logic             transmit_pin,
  output logic             rx_irq,
  output logic             osc_request,
  output logic             rx_clock_enable,
  output logic             system_wake
);

  ctrl_t       ctrl_ff;
  status_t     st_ff;
  status_t     nxt_st;
  rx_state_t   state_ff;
  logic [15:0] baud_ff;
  logic [7:0]  tx_pulse_ff;
  logic [6:0]  rx_pulse_ff;
  logic [8:0]  rx_data_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        mapped;
  logic [31:0] rd_value;
  logic        wr_now;
  logic        rd_now;

  //----------------------------------------------------------------------------
  // APB slave: one wait state so read data comes from a flop
  //----------------------------------------------------------------------------
  assign wr_now = psel & penable & pready_ff & pwrite;
  assign rd_now = psel & penable & pready_ff & ~pwrite;
  assign mapped = (paddr == CTRL_OFFSET) | (paddr == STATUS_OFFSET) |
                  (paddr == BAUD_OFFSET) | (paddr == TX_PULSE_OFFSET) |
                  (paddr == RX_PULSE_OFFSET) | (paddr == RX_DATA_OFFSET) |
                  (paddr == TX_DATA_OFFSET);

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (paddr)
      CTRL_OFFSET:     rd_value = {13'h0000, ctrl_ff};
      STATUS_OFFSET:   rd_value = {26'h000_0000, st_ff};
      BAUD_OFFSET:     rd_value = {16'h0000, baud_ff};
      TX_PULSE_OFFSET: rd_value = {24'h00_0000, tx_pulse_ff};
      RX_PULSE_OFFSET: rd_value = {25'h000_0000, rx_pulse_ff};
      RX_DATA_OFFSET:  rd_value = {23'h00_0000, rx_data_ff};
      default:         rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else if (psel & penable & ~pready_ff)
    begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff  <= rd_value;
    end
    else
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  //----------------------------------------------------------------------------
  // Line source selection and edge detection
  //----------------------------------------------------------------------------
  logic       ir_mode;
  logic       ds_eff;
  logic [16:0] step;
  logic [9:0] bit_clocks;
  logic       pin_src;
  logic       ir_pulse_in;
  logic [6:0] ir_high_ff;
  logic       ir_hit_ff;
  logic       ir_trigger;
  logic [9:0] ir_hold_ff;
  logic       tx_line_ff;
  logic       rx_line;
  logic       line_ff;
  logic       prev_ff;
  logic       fall;
  logic       rise;

  assign ir_mode     = ctrl_ff.communication_mode_field == CM_INFRARED;
  assign ds_eff      = ctrl_ff.double_speed & ~ir_mode;
  assign step        = ds_eff ? ACC_STEP_2X : ACC_STEP;
  assign bit_clocks  = ds_eff ? {1'b0, baud_ff[15:7]} : baud_ff[15:6];
  assign pin_src     = ctrl_ff.event_input_select ? event_rx_in : receive_pin;
  assign ir_pulse_in = ir_mode & ~pin_src;
  assign ir_trigger  = ir_pulse_in & ~ir_hit_ff &
                       ({1'b0, ir_high_ff} + 8'h01 >= {1'b0, rx_pulse_ff});

  // Decoder: a qualified pulse holds the line low for one bit time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_high_ff <= 7'h00;
      ir_hit_ff  <= 1'b0;
      ir_hold_ff <= 10'h000;
    end
    else
    begin
      ir_high_ff <= ir_pulse_in ? ((ir_high_ff == 7'h7f) ? ir_high_ff : ir_high_ff + 7'h01)
                                : 7'h00;
      ir_hit_ff  <= ir_pulse_in & (ir_hit_ff | ir_trigger);
      if (ir_trigger)
        ir_hold_ff <= bit_clocks;
      else if (ir_hold_ff != 10'h000)
        ir_hold_ff <= ir_hold_ff - 10'h001;
    end
  end

  always_comb
  begin
    if (ctrl_ff.one_wire_mode)
      rx_line = tx_line_ff;
    else if (ir_mode)
      rx_line = (ir_hold_ff == 10'h000) & ~ir_trigger;
    else
      rx_line = pin_src;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      line_ff <= rx_line;
      prev_ff <= line_ff;
    end
  end

  assign fall = prev_ff & ~line_ff;
  assign rise = ~prev_ff & line_ff;

  //----------------------------------------------------------------------------
  // Receiver, break detector and sync measurement
  //----------------------------------------------------------------------------
  logic [16:0] rx_acc_ff;
  logic        rx_tick;
  logic [3:0]  bit_idx_ff;
  logic [8:0]  shift_ff;
  logic [23:0] low_cnt_ff;
  logic        autobaud;
  logic        brk_long;
  logic        start_evt;
  logic        false_start;
  logic        frame_done;
  logic        accept;
  logic        type_bit;
  logic [19:0] meas_ff;
  logic [15:0] iv_ff;
  logic [15:0] iv_min_ff;
  logic [15:0] iv_max_ff;
  logic [15:0] iv_now;
  logic [15:0] iv_lo;
  logic [15:0] iv_hi;
  logic [2:0]  falls_ff;
  logic [2:0]  rises_ff;
  logic        sync_end;
  logic        strict_ok;
  logic        range_ok;
  logic        baud_load;
  logic        isf_set;
  logic        brk_set;
  logic        in_autobaud;
  logic        armed;

  assign rx_tick     = (rx_acc_ff + step) >= {1'b0, baud_ff};
  assign autobaud    = ctrl_ff.receive_mode_select != RXM_NORMAL;
  assign brk_long    = low_cnt_ff > ({8'h00, baud_ff} * BREAK_BITS);
  assign in_autobaud = state_ff[2];
  assign start_evt   = (state_ff == RX_IDLE) & ctrl_ff.rx_enable & fall & ~st_ff.wait_for_break;
  assign false_start = (state_ff == RX_START) & rx_tick & line_ff;
  assign type_bit    = (ctrl_ff.char_size == 4'h9) ? shift_ff[8] : line_ff;
  assign frame_done  = (state_ff == RX_STOP) & rx_tick;
  assign accept      = ~ctrl_ff.multiprocessor_filter_mode | type_bit;
  assign iv_now      = iv_ff + 16'h0001;
  assign iv_lo       = (iv_now < iv_min_ff) ? iv_now : iv_min_ff;
  assign iv_hi       = (iv_now > iv_max_ff) ? iv_now : iv_max_ff;
  assign sync_end    = (state_ff == AB_MEASURE) & fall & (falls_ff == SYNC_FALLS - 3'h1);
  // Edge pattern and even spacing stand for the 0x55 check and bit validity
  assign strict_ok   = (rises_ff == SYNC_RISES) & (meas_ff <= BAUD_MAX) &
                       ((iv_hi - iv_lo) <= {3'h0, meas_ff[18:6]});
  assign range_ok    = (meas_ff + SYNC_STEP >= BAUD_MIN) & (meas_ff + SYNC_STEP <= BAUD_MAX);
  assign baud_load   = sync_end & ((ctrl_ff.receive_mode_select == RXM_STRICT) ? strict_ok
                                   : range_ok);
  assign isf_set     = sync_end & (ctrl_ff.receive_mode_select == RXM_STRICT) & ~strict_ok;
  assign brk_set     = autobaud & ctrl_ff.rx_enable &
                       ((brk_long & ~in_autobaud) |
                        ((state_ff == AB_BREAK) & rise & st_ff.wait_for_break));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_ff <= 24'h00_0000;
    else if (line_ff)
      low_cnt_ff <= 24'h00_0000;
    else if (low_cnt_ff != 24'hff_ffff)
      low_cnt_ff <= low_cnt_ff + {7'h00, step};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= RX_IDLE;
      rx_acc_ff  <= 17'h0_0000;
      bit_idx_ff <= 4'h0;
      shift_ff   <= 9'h000;
    end
    else if (!ctrl_ff.rx_enable)
      state_ff <= RX_IDLE;
    else if (brk_long & autobaud & ~in_autobaud)
      state_ff <= AB_BREAK;
    else
    begin
      rx_acc_ff <= rx_tick ? rx_acc_ff + step - {1'b0, baud_ff} : rx_acc_ff + step;
      case (state_ff)
        RX_IDLE:
        begin
          rx_acc_ff <= {2'b00, baud_ff[15:1]};
          shift_ff  <= 9'h000;
          if (fall & st_ff.wait_for_break & autobaud)
            state_ff <= AB_BREAK;
          else if (start_evt)
            state_ff <= RX_START;
        end
        RX_START:
          if (rx_tick)
          begin
            bit_idx_ff <= 4'h0;
            state_ff   <= line_ff ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_tick)
          begin
            shift_ff[bit_idx_ff] <= line_ff;
            bit_idx_ff           <= bit_idx_ff + 4'h1;
            if (bit_idx_ff == ctrl_ff.char_size - 4'h1)
              state_ff <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
            state_ff <= RX_IDLE;
        AB_BREAK:
          if (rise)
            state_ff <= AB_SYNC_WAIT;
        AB_SYNC_WAIT:
          if (fall)
            state_ff <= AB_MEASURE;
        AB_MEASURE:
          if (sync_end)
            state_ff <= AB_TAIL;
        AB_TAIL:
          if (rise)
            state_ff <= RX_IDLE;
        default:
          state_ff <= RX_IDLE;
      endcase
    end
  end

  // Sync measurement: eight counts per clock over eight bit times gives 64x
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas_ff   <= 20'h0_0000;
      iv_ff     <= 16'h0000;
      iv_min_ff <= 16'hffff;
      iv_max_ff <= 16'h0000;
      falls_ff  <= 3'h0;
      rises_ff  <= 3'h0;
    end
    else if (state_ff != AB_MEASURE)
    begin
      meas_ff   <= 20'h0_0000;
      iv_ff     <= 16'h0000;
      iv_min_ff <= 16'hffff;
      iv_max_ff <= 16'h0000;
      falls_ff  <= 3'h0;
      rises_ff  <= 3'h0;
    end
    else
    begin
      if (meas_ff != 20'hf_fff8)
        meas_ff <= meas_ff + SYNC_STEP;
      iv_ff <= fall ? 16'h0000 : ((iv_ff == 16'hffff) ? iv_ff : iv_now);
      if (fall)
      begin
        iv_min_ff <= iv_lo;
        iv_max_ff <= iv_hi;
        falls_ff  <= falls_ff + 3'h1;
      end
      if (rise & (rises_ff != 3'h7))
        rises_ff <= rises_ff + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_data_ff <= 9'h000;
    else if (frame_done & accept)
      rx_data_ff <= shift_ff;
  end

  //----------------------------------------------------------------------------
  // Registers written by software, with hardware updates
  //----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff     <= ctrl_t'(CTRL_RESET);
      tx_pulse_ff <= TX_PULSE_RESET;
      rx_pulse_ff <= RX_PULSE_RESET;
    end
    else if (wr_now)
    begin
      if (paddr == CTRL_OFFSET)
        ctrl_ff <= ctrl_t'(pwdata[18:0]);
      if (paddr == TX_PULSE_OFFSET)
        tx_pulse_ff <= pwdata[7:0];
      if (paddr == RX_PULSE_OFFSET)
        rx_pulse_ff <= pwdata[6:0];
    end
  end

  // A rejected measurement never reaches this register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_ff <= BAUD_RESET;
    else if (baud_load)
      baud_ff <= meas_ff[15:0] + SYNC_STEP[15:0];
    else if (wr_now & (paddr == BAUD_OFFSET))
      baud_ff <= pwdata[15:0];
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always_comb
  begin
    nxt_st = st_ff;
    if (wr_now & (paddr == STATUS_OFFSET))
    begin
      nxt_st.receive_complete_flag  = st_ff.receive_complete_flag & ~pwdata[0];
      nxt_st.start_detected_flag    = st_ff.start_detected_flag & ~pwdata[1];
      nxt_st.inconsistent_sync_flag = st_ff.inconsistent_sync_flag & ~pwdata[2];
      nxt_st.break_flag             = st_ff.break_flag & ~pwdata[3];
      nxt_st.wait_for_break         = st_ff.wait_for_break | pwdata[4];
    end
    if (rd_now & (paddr == RX_DATA_OFFSET))
      nxt_st.receive_complete_flag = 1'b0;
    if (!ctrl_ff.rx_enable)
      nxt_st.receive_complete_flag = 1'b0;
    if (frame_done & accept)
      nxt_st.receive_complete_flag = 1'b1;
    if (start_evt & armed)
      nxt_st.start_detected_flag = 1'b1;
    if (isf_set)
      nxt_st.inconsistent_sync_flag = 1'b1;
    if (brk_set)
    begin
      nxt_st.break_flag     = 1'b1;
      nxt_st.wait_for_break = 1'b0;
    end
    nxt_st.rx_busy = state_ff != RX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= status_t'(6'h00);
    else
      st_ff <= nxt_st;
  end

  //----------------------------------------------------------------------------
  // Start-frame wake-up and shared interrupt line
  //----------------------------------------------------------------------------
  logic session_ff;
  logic nxt_session;
  logic wake_ff;
  logic irq_ff;
  logic osc_ff;
  logic clk_en_ff;

  assign armed = ctrl_ff.start_frame_detect_enable & ctrl_ff.rx_enable &
                 (ctrl_ff.communication_mode_field == CM_ASYNC) &
                 (sleep_state == SLP_STANDBY);

  always_comb
  begin
    nxt_session = session_ff;
    if (sleep_state != SLP_STANDBY)
      nxt_session = 1'b0;
    else if (start_evt & armed)
      nxt_session = 1'b1;
    else if ((false_start & ~other_wake) | frame_done)
      nxt_session = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      session_ff <= 1'b0;
      osc_ff     <= 1'b1;
      clk_en_ff  <= 1'b1;
      wake_ff    <= 1'b0;
      irq_ff     <= 1'b0;
    end
    else
    begin
      session_ff <= nxt_session;
      // Sleep entry cannot stop the oscillator mid-frame
      osc_ff     <= (sleep_state == SLP_ACTIVE) | nxt_session |
                    (state_ff != RX_IDLE) | start_evt;
      clk_en_ff  <= (sleep_state != SLP_STANDBY) | nxt_session;
      if (sleep_state == SLP_ACTIVE)
        wake_ff <= 1'b0;
      else if (armed & start_evt & ctrl_ff.start_int_en)
        wake_ff <= 1'b1;
      else if (session_ff & frame_done & accept & ctrl_ff.done_int_en &
               ~ctrl_ff.start_int_en)
        wake_ff <= 1'b1;
      irq_ff <= (nxt_st.receive_complete_flag & ctrl_ff.done_int_en) |
                (nxt_st.start_detected_flag & ctrl_ff.start_int_en);
    end
  end

  assign rx_irq          = irq_ff;
  assign osc_request     = osc_ff;
  assign rx_clock_enable = clk_en_ff;
  assign system_wake     = wake_ff;

  //----------------------------------------------------------------------------
  // Transmitter with infrared pulse shaping
  //----------------------------------------------------------------------------
  logic [16:0] tx_acc_ff;
  logic        tx_tick;
  logic        tx_busy_ff;
  logic [9:0]  tx_shift_ff;
  logic [3:0]  tx_left_ff;
  logic [8:0]  char_mask;
  logic        tx_load;
  logic [7:0]  ir_cnt_ff;
  logic [17:0] baud_x3;
  logic [7:0]  pulse_len;
  logic        pin_ff;

  assign tx_tick   = (tx_acc_ff + step) >= {1'b0, baud_ff};
  assign char_mask = ~(9'h1ff << ctrl_ff.char_size);
  assign tx_load   = wr_now & (paddr == TX_DATA_OFFSET) & ~tx_busy_ff & ctrl_ff.tx_enable;
  assign baud_x3   = {2'b00, baud_ff} * 18'h0_0003;

  always_comb
  begin
    case (ctrl_ff.ir_tx_pulse_mode)
      IRP_3_16:  pulse_len = ds_eff ? {1'b0, baud_x3[17:11]} : baud_x3[17:10];
      IRP_FIXED: pulse_len = tx_pulse_ff;
      default:   pulse_len = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_acc_ff   <= 17'h0_0000;
      tx_busy_ff  <= 1'b0;
      tx_shift_ff <= 10'h3ff;
      tx_left_ff  <= 4'h0;
      tx_line_ff  <= 1'b1;
      ir_cnt_ff   <= 8'h00;
    end
    else
    begin
      tx_acc_ff <= tx_tick ? tx_acc_ff + step - {1'b0, baud_ff} : tx_acc_ff + step;
      if (ir_cnt_ff != 8'h00)
        ir_cnt_ff <= ir_cnt_ff - 8'h01;
      if (tx_load)
      begin
        tx_acc_ff   <= 17'h0_0000;
        tx_busy_ff  <= 1'b1;
        tx_shift_ff <= {1'b1, pwdata[8:0] | ~char_mask};
        tx_left_ff  <= ctrl_ff.char_size + 4'h1;
        tx_line_ff  <= 1'b0;
        ir_cnt_ff   <= pulse_len;
      end
      else if (tx_busy_ff & tx_tick)
      begin
        if (tx_left_ff != 4'h0)
        begin
          tx_line_ff  <= tx_shift_ff[0];
          tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
          tx_left_ff  <= tx_left_ff - 4'h1;
          if (!tx_shift_ff[0])
            ir_cnt_ff <= pulse_len;
        end
        else
          tx_busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_ff <= 1'b1;
    else if (ir_mode & (ctrl_ff.ir_tx_pulse_mode != IRP_NONE))
      pin_ff <= ir_cnt_ff == 8'h00;
    else
      pin_ff <= tx_line_ff;
  end

  assign transmit_pin = pin_ff;

endmodule

// ===== tb/uart_rx_sva.sv
`timescale 1ns/100ps
module uart_rx_sva
  import uart_rx_modes_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [1:0] sleep_state,
  input wire logic       rx_irq,
  input wire logic       osc_request,
  input wire logic       rx_clock_enable,
  input wire logic       system_wake
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_qual; pready |-> psel && penable; endproperty
  a_qual: assert property (p_qual) else $error("stray ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_osc; sleep_state == 2'h0 |=> osc_request; endproperty
  a_osc: assert property (p_osc) else $error("osc off");
  property p_clk; sleep_state != 2'h2 |=> rx_clock_enable; endproperty
  a_clk: assert property (p_clk) else $error("rx clock off");
  property p_wake; (sleep_state == 2'h0) [*2] |-> !system_wake; endproperty
  a_wake: assert property (p_wake) else $error("wake held");
  // Only a bus access may clear a flag or an enable, so only then may the request drop
  property p_irq; $fell(rx_irq) |-> $past(psel) || $past(psel, 2) || $past(psel, 3); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
endmodule
bind uart_rx_special_modes uart_rx_sva i_uart_rx_sva (.*);

// ===== tb/far_tx.sv
`timescale 1ns/100ps
module far_tx
(
  output logic      line,
  input  wire logic pclk
);
  // Driven high from time zero, so the idle line reads high
  initial line = 1'b1;
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge pclk);
  endtask
  task automatic frame(input logic [9:0] v, input int nb, input int bc);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++)
      hold(v[i], bc);
    hold(1'b1, 2 * bc);
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb
  import uart_rx_modes_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, rx_line, rx_irq, osc, clk_en, wake;
  logic [1:0]  sleep = 2'h0;
  int          n_mismatch = 0;
  int          checked = 0;
  always #4 pclk = ~pclk;
  far_tx i_far_tx (.pclk(pclk), .line(rx_line));
  uart_rx_special_modes i_uart_rx_special_modes (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .receive_pin(rx_line),
    .event_rx_in(1'b1), .sleep_state(sleep), .other_wake(1'b0), .transmit_pin(),
    .rx_irq(rx_irq), .osc_request(osc), .rx_clock_enable(clk_en), .system_wake(wake));
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Starts a clock after the last release so no strobe is written twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic t_regs;
    rdchk(CTRL_OFFSET, 32'h0000_2000);
    rdchk(BAUD_OFFSET, 32'h0000_0400);
    rdchk(8'h1c, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask
  task automatic t_frame;
    apb(1'b1, CTRL_OFFSET, 32'h0002_2001);
    i_far_tx.frame(10'h1a5, 9, 16);
    chk({31'h0, rx_irq}, 32'h0000_0001);
    rdchk(STATUS_OFFSET, 32'h0000_0001);
    rdchk(RX_DATA_OFFSET, 32'h0000_00a5);
    repeat (4) @(posedge pclk);
    chk({31'h0, rx_irq}, 32'h0000_0000);
  endtask
  // False start in standby: clock up on the edge, down at mid start bit
  task automatic t_wake;
    apb(1'b1, CTRL_OFFSET, 32'h0004_2005);
    sleep <= 2'h2;
    i_far_tx.hold(1'b0, 4);
    chk({30'h0, clk_en, osc}, 32'h0000_0003);
    i_far_tx.hold(1'b1, 20);
    chk({30'h0, clk_en, wake}, 32'h0000_0001);
    sleep <= 2'h0;
    rdchk(STATUS_OFFSET, 32'h0000_0002);
  endtask
  task automatic t_wire;
    apb(1'b1, CTRL_OFFSET, 32'h0000_200b);
    apb(1'b1, TX_DATA_OFFSET, 32'h0000_00c3);
    repeat (200) @(posedge pclk);
    rdchk(RX_DATA_OFFSET, 32'h0000_00c3);
  endtask
  task automatic t_mp;
    apb(1'b1, CTRL_OFFSET, 32'h0002_2011);
    i_far_tx.frame(10'h03c, 9, 16);
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    i_far_tx.frame(10'h15a, 9, 16);
    rdchk(RX_DATA_OFFSET, 32'h0000_005a);
  endtask
  task automatic t_sync(input logic [31:0] c, input int brk, input logic [9:0] v,
                        input int nb, input int bc, input logic [31:0] baud);
    apb(1'b1, CTRL_OFFSET, c);
    i_far_tx.hold(1'b0, brk);
    i_far_tx.hold(1'b1, 40);
    i_far_tx.frame(v, nb, bc);
    rdchk(BAUD_OFFSET, baud);
  endtask
  task automatic t_strict;
    // Fall spacing 40/80/40/40 clocks is not a clean sync pattern
    t_sync(32'h0000_2041, 300, 10'h15d, 10, 20, 32'h0000_0500);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk({29'h0, rd[2], 2'h0}, 32'h0000_0004);
  endtask
  task automatic t_wfb;
    apb(1'b1, STATUS_OFFSET, 32'h0000_0010);
    t_sync(32'h0000_2021, 10, 10'h155, 9, 12, 32'h0000_0300);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_frame();
    t_mp();
    t_wake();
    t_wire();
    t_sync(32'h0000_2021, 200, 10'h155, 9, 20, 32'h0000_0500);
    t_strict();
    t_wfb();
    close_out();
  end
endmodule
